// >>> hdl/arb_pkg.sv
package arb_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int MASTER_COUNT = 4;

  // ****************************************************************
  // Latch field positions on the processor data lines
  // ****************************************************************
  localparam int LATCH_ENABLE_POS = 2;
  localparam int LATCH_MASTER_MSB = 1;
  localparam int LATCH_MASTER_LSB = 0;

  // ****************************************************************
  // Reset values and counter step
  // ****************************************************************
  localparam logic       LATCH_ENABLE_RESET = 1'h0;
  localparam logic [1:0] LATCH_MASTER_RESET = 2'h0;
  localparam logic [1:0] COUNT_RESET        = 2'h0;
  localparam logic [1:0] PRIORITY_RESET     = 2'h0;
  localparam logic [1:0] COUNT_STEP         = 2'h1;

  // ****************************************************************
  // Handshake states: upper nibble state code, lower nibble grants
  // ****************************************************************
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h00,
    ST_AWAIT0 = 8'h41,
    ST_AWAIT1 = 8'h42,
    ST_AWAIT2 = 8'h84,
    ST_AWAIT3 = 8'h88,
    ST_BUSY0  = 8'h11,
    ST_BUSY1  = 8'h12,
    ST_BUSY2  = 8'h14,
    ST_BUSY3  = 8'h18,
    ST_HOLD0  = 8'h21,
    ST_HOLD1  = 8'h22,
    ST_HOLD2  = 8'h24,
    ST_HOLD3  = 8'h28
  } arb_state_t;

endpackage

// >>> hdl/bus_arbiter.sv
`timescale 1ns/1ps
module bus_arbiter
  import arb_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       bus_clock,
  input  wire logic [3:0] master_request_n,
  input  wire logic       shared_bus_busy_n,
  input  wire logic       chip_select_n,
  input  wire logic       write_enable_n,
  input  wire logic       data_bit_two,
  input  wire logic       data_bit_one,
  input  wire logic       data_bit_zero,
  output logic      [3:0] master_grant_n,
  output logic            state_bit_three,
  output logic            state_bit_two,
  output logic            state_bit_one,
  output logic            state_bit_zero,
  output logic      [1:0] selected_priority,
  output logic      [1:0] random_count,
  output logic            override_enable
);

  // ****************************************************************
  // Priority source
  // ****************************************************************
  prio_if prio ();

  priority_unit u_priority (
    .clk            (core_clk),
    .rst_n          (rst_n),
    .chip_select_n  (chip_select_n),
    .write_enable_n (write_enable_n),
    .data_bit_two   (data_bit_two),
    .data_bit_one   (data_bit_one),
    .data_bit_zero  (data_bit_zero),
    .prio           (prio.src)
  );

  // ****************************************************************
  // Input synchronisers and bus-rate sampling
  // ****************************************************************
  logic [5:0] in_meta_reg;
  logic [5:0] in_sync_reg;
  logic       bus_clock_last_reg;
  logic [3:0] req_sample_reg;
  logic [3:0] req_sample_next;
  logic       bus_edge;

  // Two flops on each pin: bus clock, busy, requests
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      in_meta_reg <= 6'h3F;
      in_sync_reg <= 6'h3F;
    end else begin
      in_meta_reg <= {bus_clock, shared_bus_busy_n, master_request_n};
      in_sync_reg <= in_meta_reg;
    end
  end

  // Rising edge of the bus clock picks the request sample
  always_comb begin
    bus_edge        = in_sync_reg[5] && !bus_clock_last_reg;
    req_sample_next = bus_edge ? ~in_sync_reg[3:0] : req_sample_reg;
  end

  // Sample registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_clock_last_reg <= 1'h1;
      req_sample_reg     <= 4'h0;
    end else begin
      bus_clock_last_reg <= in_sync_reg[5];
      req_sample_reg     <= req_sample_next;
    end
  end

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // Rank from the selected code downward, wrapping
  function automatic logic [1:0] pick_winner(input logic [3:0] req, input logic [1:0] code);
    logic [1:0] idx;
    logic [1:0] win;
    logic       found;
    win   = code;
    found = 1'h0;
    for (int i = 0; i < MASTER_COUNT; i++) begin
      idx = code - i[1:0];
      if (!found && req[idx]) begin
        win   = idx;
        found = 1'h1;
      end
    end
    return win;
  endfunction

  // First wait state for a master
  function automatic arb_state_t await_of(input logic [1:0] m);
    arb_state_t s;
    case (m)
      2'h0: s = ST_AWAIT0;
      2'h1: s = ST_AWAIT1;
      2'h2: s = ST_AWAIT2;
      default: s = ST_AWAIT3;
    endcase
    return s;
  endfunction

  // ****************************************************************
  // Handshake state machine
  // ****************************************************************
  arb_state_t state_reg;
  arb_state_t state_next;
  logic       busy_seen;
  logic       any_req;
  logic [1:0] winner;

  // Next state
  always_comb begin
    busy_seen  = !in_sync_reg[4];
    any_req    = |req_sample_reg;
    winner     = pick_winner(req_sample_reg, prio.selected_priority);
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (any_req) begin
          state_next = await_of(winner);
        end
      end
      ST_AWAIT0, ST_AWAIT1, ST_AWAIT2, ST_AWAIT3: begin
        if (!busy_seen) begin
          state_next = arb_state_t'({4'h1, state_reg[3:0]});
        end
      end
      ST_BUSY0, ST_BUSY1, ST_BUSY2, ST_BUSY3: begin
        if (busy_seen) begin
          state_next = arb_state_t'({4'h2, state_reg[3:0]});
        end
      end
      ST_HOLD0, ST_HOLD1, ST_HOLD2, ST_HOLD3: begin
        if (any_req) begin
          state_next = await_of(winner);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign master_grant_n    = ~state_reg[3:0];
  assign state_bit_three   = state_reg[7];
  assign state_bit_two     = state_reg[6];
  assign state_bit_one     = state_reg[5];
  assign state_bit_zero    = state_reg[4];
  assign selected_priority = prio.selected_priority;
  assign random_count      = prio.random_count;
  assign override_enable   = prio.override_enable;

endmodule

// >>> hdl/prio_if.sv
`timescale 1ns/1ps
interface prio_if;
  logic [1:0] selected_priority;
  logic [1:0] random_count;
  logic       override_enable;
  modport src  (output selected_priority, output random_count, output override_enable);
  modport sink (input selected_priority, input random_count, input override_enable);
endinterface

// >>> hdl/priority_unit.sv
`timescale 1ns/1ps
module priority_unit
  import arb_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic chip_select_n,
  input  wire logic write_enable_n,
  input  wire logic data_bit_two,
  input  wire logic data_bit_one,
  input  wire logic data_bit_zero,
  prio_if.src       prio
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic       enable_reg;
  logic       enable_next;
  logic [1:0] master_reg;
  logic [1:0] master_next;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic [1:0] select_reg;
  logic [1:0] select_next;
  logic       store_hit;

  // Two flops on every processor pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_reg <= 5'h1F;
      pin_sync_reg <= 5'h1F;
    end else begin
      pin_meta_reg <= {chip_select_n, write_enable_n, data_bit_two, data_bit_one,
                       data_bit_zero};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ****************************************************************
  // Latch, counter and selector
  // ****************************************************************
  // Next values
  always_comb begin
    store_hit   = !pin_sync_reg[4] && !pin_sync_reg[3];
    enable_next = enable_reg;
    master_next = master_reg;
    if (store_hit) begin
      enable_next = pin_sync_reg[LATCH_ENABLE_POS];
      master_next = pin_sync_reg[LATCH_MASTER_MSB:LATCH_MASTER_LSB];
    end
    count_next  = count_reg + COUNT_STEP;
    select_next = enable_reg ? master_reg : count_reg;
  end

  // Registers, cleared by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg <= LATCH_ENABLE_RESET;
      master_reg <= LATCH_MASTER_RESET;
      count_reg  <= COUNT_RESET;
      select_reg <= PRIORITY_RESET;
    end else begin
      enable_reg <= enable_next;
      master_reg <= master_next;
      count_reg  <= count_next;
      select_reg <= select_next;
    end
  end

  assign prio.selected_priority = select_reg;
  assign prio.random_count      = count_reg;
  assign prio.override_enable   = enable_reg;

endmodule

// >>> sim/arb_master_model.sv
`timescale 1ns/1ps
// ****
// Bus master group
// ****
module arb_master_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] want,
  input  wire logic [2:0] lag,
  input  wire logic [3:0] master_grant_n,
  output logic      [3:0] master_request_n,
  output logic            shared_bus_busy_n
);
  logic [3:0] served;
  logic [3:0] mine;
  int         wait_cnt = 0;
  int         use_cnt = 0;
  initial begin
    master_request_n = 4'hF;
    shared_bus_busy_n = 1'b1;
    served = 4'h0;
  end
  // Granted and still wanting
  assign mine = ~master_grant_n & want & ~served;
  // Drop request on grant, take bus after lag, release busy to pull-up
  always @(posedge core_clk) begin
    #1;
    master_request_n <= ~(want & ~served & ~mine);
    served <= (served | mine) & want;
    if (use_cnt > 0) begin
      use_cnt <= use_cnt - 1;
      shared_bus_busy_n <= (use_cnt == 1);
    end else if (mine != 4'h0 || wait_cnt > 0) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= lag) begin
        wait_cnt <= 0;
        use_cnt <= 6;
        shared_bus_busy_n <= 1'b0;
      end
    end
  end
endmodule

// >>> sim/bus_arbiter_checker.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module bus_arbiter_checker (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [3:0] master_request_n,
  input wire logic       shared_bus_busy_n,
  input wire logic       chip_select_n,
  input wire logic       write_enable_n,
  input wire logic [3:0] master_grant_n,
  input wire logic       state_bit_three,
  input wire logic       state_bit_two,
  input wire logic       state_bit_one,
  input wire logic       state_bit_zero,
  input wire logic [1:0] selected_priority,
  input wire logic [1:0] random_count,
  input wire logic       override_enable
);
  logic [3:0] st;
  logic       store_pins;
  // State nibble and store strobe
  assign st = {state_bit_three, state_bit_two, state_bit_one, state_bit_zero};
  assign store_pins = !chip_select_n && !write_enable_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_await_free;
    ((st == 4'h4 || st == 4'h8) && shared_bus_busy_n) [*3];
  endsequence
  sequence s_wait_taken;
    (st == 4'h1 && !shared_bus_busy_n) [*3];
  endsequence
  property p_reset_idle;
    disable iff (1'b0) !rst_n |=> master_grant_n == 4'hF && st == 4'h0
      && random_count == 2'h0 && selected_priority == 2'h0 && !override_enable;
  endproperty
  property p_count;
    $past(rst_n) |-> random_count == $past(random_count) + 2'h1;
  endproperty
  property p_select;
    $past(rst_n) && !$past(override_enable) |-> selected_priority == $past(random_count);
  endproperty
  property p_latch_hold;
    !$stable(override_enable) |->
      $past(store_pins, 3) || $past(store_pins, 4) || $past(store_pins, 5);
  endproperty
  property p_grant_once;
    st == 4'h0 && master_request_n == 4'hE |-> ##[1:12] master_grant_n == 4'hE;
  endproperty
  property p_await_free;
    s_await_free |=> st == 4'h1 && master_grant_n == $past(master_grant_n);
  endproperty
  property p_taken;
    s_wait_taken |=> st == 4'h2 && $stable(master_grant_n);
  endproperty
  property p_hold_grant;
    st == 4'h4 || st == 4'h8 || st == 4'h1 |=> $stable(master_grant_n);
  endproperty
  property p_code;
    (st == 4'h0) == (master_grant_n == 4'hF) && $onehot0(~master_grant_n);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset state wrong");
  a_count: assert property (p_count) else $error("counter skipped");
  a_select: assert property (p_select) else $error("selector wrong");
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved");
  a_grant_once: assert property (p_grant_once) else $error("no grant");
  a_await_free: assert property (p_await_free) else $error("no busy wait");
  a_taken: assert property (p_taken) else $error("no hold");
  a_hold_grant: assert property (p_hold_grant) else $error("grant moved");
  a_code: assert property (p_code) else $error("bad state code");
endmodule
bind bus_arbiter bus_arbiter_checker bus_arbiter_checker_i (
  .core_clk(core_clk), .rst_n(rst_n), .master_request_n(master_request_n),
  .shared_bus_busy_n(shared_bus_busy_n), .chip_select_n(chip_select_n),
  .write_enable_n(write_enable_n), .master_grant_n(master_grant_n),
  .state_bit_three(state_bit_three), .state_bit_two(state_bit_two),
  .state_bit_one(state_bit_one), .state_bit_zero(state_bit_zero),
  .selected_priority(selected_priority), .random_count(random_count),
  .override_enable(override_enable));

// >>> sim/bus_arbiter_test.sv
`timescale 1ns/1ps
// ****
// Arbiter bench
// ****
module bus_arbiter_test;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       bus_clock = 1'b0;
  logic       chip_select_n = 1'b1;
  logic       write_enable_n = 1'b1;
  logic [2:0] data = 3'h0;
  logic [3:0] want = 4'h0;
  logic [2:0] lag = 3'h4;
  logic [3:0] master_request_n;
  logic       shared_bus_busy_n;
  logic [3:0] master_grant_n;
  logic [3:0] st;
  logic [1:0] selected_priority;
  logic [1:0] random_count;
  logic       override_enable;
  logic [3:0] mask;
  int         num_errors = 0;
  int         comparisons = 0;
  bus_arbiter bus_arbiter_i (.core_clk(core_clk), .rst_n(rst_n), .bus_clock(bus_clock),
    .master_request_n(master_request_n), .shared_bus_busy_n(shared_bus_busy_n),
    .chip_select_n(chip_select_n), .write_enable_n(write_enable_n),
    .data_bit_two(data[2]), .data_bit_one(data[1]), .data_bit_zero(data[0]),
    .master_grant_n(master_grant_n), .state_bit_three(st[3]), .state_bit_two(st[2]),
    .state_bit_one(st[1]), .state_bit_zero(st[0]), .selected_priority(selected_priority),
    .random_count(random_count), .override_enable(override_enable));
  arb_master_model arb_master_model_i (.core_clk(core_clk), .want(want), .lag(lag),
    .master_grant_n(master_grant_n), .master_request_n(master_request_n),
    .shared_bus_busy_n(shared_bus_busy_n));
  // Fast clock and half-rate bus clock
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) bus_clock <= #1 ~bus_clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wait_code(input logic [3:0] a, input logic [3:0] b);
    int i;
    for (i = 0; i < 200 && st !== a && st !== b; i++) tick(1);
    if (i == 200) begin
      num_errors++;
      $display("unexpected at %0t: state wait ran out", $time);
      end_of_test();
    end
  endtask
  task automatic store(input logic [2:0] v);
    chip_select_n = 1'b0;
    write_enable_n = 1'b0;
    data = v;
    tick(2);
    chip_select_n = 1'b1;
    write_enable_n = 1'b1;
    data = ~v;
    tick(6);
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    tick(6);
    check({st, master_grant_n}, 8'h0F);
    check({override_enable, selected_priority, random_count}, 8'h00);
    rst_n = 1'b1;
  endtask
  task automatic arbitrate(input logic [3:0] m, input int win);
    want = m;
    wait_code(4'h4, 4'h8);
    check({st, master_grant_n}, {win < 2 ? 4'h4 : 4'h8, ~(4'h1 << win)});
    want = 4'h1 << win;
    wait_code(4'h1, 4'h1);
    check({st, master_grant_n}, {4'h1, ~(4'h1 << win)});
    wait_code(4'h2, 4'h2);
    check({st, master_grant_n}, {4'h2, ~(4'h1 << win)});
    want = 4'h0;
  endtask
  // Main sequence
  initial begin
    do_reset();
    for (int i = 1; i < 6; i++) begin
      tick(1);
      check({6'h0, random_count}, 8'(i % 4));
    end
    arbitrate(4'h1, 0);
    $display("test reset and count done");
    // Descending codes keep the last hold owner out of the next first winner
    for (int p = 3; p >= 0; p--) begin
      lag = p[0] ? 3'h6 : 3'h4;
      store({1'b1, p[1:0]});
      check({override_enable, selected_priority}, {5'h1, p[1:0]});
      for (int k = 0; k < 4; k++) begin
        mask = 4'h0;
        for (int j = k; j < 4; j++) mask[(p - j) & 3] = 1'b1;
        arbitrate(mask, (p - k) & 3);
      end
    end
    $display("test latch and ranking done");
    want = 4'h8;
    tick(12);
    want = 4'h0;
    do_reset();
    arbitrate(4'h4, 2);
    store(3'h3);
    check({override_enable, 2'h0}, 8'h00);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
